// ### rtl/otppi_consts.svh
// constants of the otp programming interface
`ifndef OTPPI_CONSTS_SVH
`define OTPPI_CONSTS_SVH
`define OTPPI_CLK_MHZ 50
`define OTPPI_OTP_WRITE_PULSE_N_TIME_US 100
`define OTPPI_OTP_WRITE_PULSE_N_CYCLES (`OTPPI_OTP_WRITE_PULSE_N_TIME_US * `OTPPI_CLK_MHZ)
`define OTPPI_MODE_RSVD 2'h0
`define OTPPI_MODE_VER 2'h1
`define OTPPI_MODE_LOCK 2'h2
`define OTPPI_MODE_MEM 2'h3
`define OTPPI_LOCK_W 2
`define OTPPI_ERASED 8'hff
`define OTPPI_VERSION0 8'h5a
`define OTPPI_VERSION1 8'ha5
`define OTPPI_VER_SEL_BIT 0
`endif

// ### rtl/otppi_pkg.sv
// types of the otp programming interface
package otppi_pkg;
    typedef enum logic [1:0] {
        OTPPI_AM_RSVD,
        OTPPI_AM_VER,
        OTPPI_AM_LOCK,
        OTPPI_AM_MEM
    } otppi_mode_t;
    typedef enum logic [1:0] {
        OTPPI_ST_IDLE,
        OTPPI_ST_ARMED,
        OTPPI_ST_ACTIVE,
        OTPPI_ST_LOCKED
    } otppi_state_t;
    typedef struct packed {
        logic [7:0] dout;
        logic [7:0] doe;
    } otppi_data_t;
endpackage

// ### rtl/otppi_edge.sv
// synchronous rise and fall detector for one pin
`timescale 1ns/1ns
module otppi_edge (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_pin,
    // edges
    output logic o_rise,
    output logic o_fall
);
    logic prev_r;
    logic prev_nxt;
    always_comb begin
        prev_nxt = i_pin;
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
        end
    end
    assign o_rise = i_pin & ~prev_r;
    assign o_fall = ~i_pin & prev_r;
endmodule

// ### rtl/otppi_top.sv
// otp program memory programming interface, device side
// How it works
// - 64 Kbyte otp array; each byte program takes about 100 us
// - in programming mode the block only answers external pins
// - data moves both ways on port 0; port 2 carries addresses in
// - upper address byte captured from port 2 on latch strobe fall
// - select code 00 reserved, 01 version, 10 lock bits, 11 memory byte
// - read strobe gates data out for memory, version and lock reads
// - on mode select fall latch write and supply levels
// - after protection set and mode left, further entry is refused
`timescale 1ns/1ns
`include "otppi_consts.svh"
module otppi_top
    import otppi_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter int OTP_WRITE_PULSE_N_CYCLES = `OTPPI_OTP_WRITE_PULSE_N_CYCLES
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // mode entry pins
    input wire logic i_reset_pin_n,
    input wire logic i_program_store_enable_n,
    input wire logic i_basic_mode_sel_n,
    input wire logic i_ext_access_program_supply,
    // access pins
    input wire logic i_upper_addr_latch_strobe,
    input wire logic i_access_mode_sel_bit0,
    input wire logic i_access_mode_sel_bit1,
    input wire logic i_otp_read_strobe_n,
    input wire logic i_otp_write_pulse_n,
    input wire logic [7:0] i_port2,
    // port 0 data
    input wire logic [7:0] i_port0,
    output logic [7:0] o_port0,
    output logic [7:0] o_port0_oe,
    // status
    output logic o_otp_write_pulse_n_mode,
    output logic o_otp_write_pulse_n_busy,
    output logic o_entry_refused
);
    localparam int CNT_W = $clog2(OTP_WRITE_PULSE_N_CYCLES + 1);
    localparam int DEPTH = 1 << ADDR_W;

    logic [7:0] mem [0:DEPTH-1];
    otppi_state_t st_r;
    otppi_state_t st_nxt;
    logic [7:0] ahi_r;
    logic [7:0] ahi_nxt;
    logic [`OTPPI_LOCK_W-1:0] lock_r;
    logic [`OTPPI_LOCK_W-1:0] lock_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic wr_en_r;
    logic wr_en_nxt;
    logic vpp_r;
    logic vpp_nxt;
    otppi_data_t dat_r;
    otppi_data_t dat_nxt;
    logic refused_r;
    logic refused_nxt;
    logic do_write;
    logic [ADDR_W-1:0] addr;
    otppi_mode_t mode;
    logic sel_fall;
    logic wr_fall;
    logic ale_fall;
    logic mode_pins;
    logic entry_ok;
    logic leave;
    logic otp_write_pulse_n_mem;
    logic otp_write_pulse_n_lock;
    logic rd_en;
    logic [7:0] rd_byte;

    otppi_edge u_sel_edge (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_basic_mode_sel_n),
        .o_rise(),
        .o_fall(sel_fall)
    );
    otppi_edge u_wr_edge (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_otp_write_pulse_n),
        .o_rise(),
        .o_fall(wr_fall)
    );
    otppi_edge u_ale_edge (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_upper_addr_latch_strobe),
        .o_rise(),
        .o_fall(ale_fall)
    );

    assign mode = otppi_mode_t'({i_access_mode_sel_bit1, i_access_mode_sel_bit0});
    assign addr = {ahi_r, i_port2};
    assign mode_pins = ~i_reset_pin_n & ~i_program_store_enable_n;
    // entry pins as the programmer sets them before mode select falls
    assign entry_ok = mode_pins
                      && sel_fall
                      && (mode == OTPPI_AM_VER)
                      && ~i_upper_addr_latch_strobe
                      && i_otp_read_strobe_n;
    assign leave = ~mode_pins | i_basic_mode_sel_n;
    // memory programs only with a latched-armed write pulse, supply high, idle timer
    assign do_write = (st_r == OTPPI_ST_ACTIVE) && ~leave && wr_en_r && vpp_r && wr_fall
                      && i_ext_access_program_supply && (cnt_r == '0);
    assign otp_write_pulse_n_mem = do_write && (mode == OTPPI_AM_MEM);
    assign otp_write_pulse_n_lock = do_write && (mode == OTPPI_AM_LOCK);
    assign rd_en = (st_r == OTPPI_ST_ACTIVE) && ~leave && ~i_otp_read_strobe_n
                   && (cnt_r == '0);

    // read byte by access code
    always_comb begin
        rd_byte = '0;
        unique case (mode)
            OTPPI_AM_MEM: rd_byte = mem[addr];
            OTPPI_AM_LOCK: rd_byte = 8'(lock_r);
            OTPPI_AM_VER: rd_byte = i_port2[`OTPPI_VER_SEL_BIT] ? `OTPPI_VERSION1
                                                                : `OTPPI_VERSION0;
            OTPPI_AM_RSVD: rd_byte = '0;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        ahi_nxt = ahi_r;
        lock_nxt = lock_r;
        cnt_nxt = cnt_r;
        wr_en_nxt = wr_en_r;
        vpp_nxt = vpp_r;
        refused_nxt = refused_r;
        dat_nxt = '0;
        unique case (st_r)
            OTPPI_ST_IDLE: begin
                if (entry_ok) begin
                    wr_en_nxt = ~i_otp_write_pulse_n;
                    vpp_nxt = ~i_ext_access_program_supply;
                    st_nxt = OTPPI_ST_ARMED;
                end
            end
            OTPPI_ST_ARMED: begin
                if (leave) begin
                    st_nxt = OTPPI_ST_IDLE;
                end else if (i_otp_write_pulse_n) begin
                    st_nxt = OTPPI_ST_ACTIVE;
                end
            end
            OTPPI_ST_ACTIVE: begin
                if (leave) begin
                    st_nxt = (lock_r != '0) ? OTPPI_ST_LOCKED : OTPPI_ST_IDLE;
                    cnt_nxt = '0;
                end else begin
                    if (ale_fall) begin
                        ahi_nxt = i_port2;
                    end
                    if (cnt_r != '0) begin
                        cnt_nxt = cnt_r - 1'b1;
                    end
                    if (otp_write_pulse_n_mem || otp_write_pulse_n_lock) begin
                        cnt_nxt = CNT_W'(OTP_WRITE_PULSE_N_CYCLES);
                    end
                    if (otp_write_pulse_n_lock) begin
                        lock_nxt = lock_r | i_port0[`OTPPI_LOCK_W-1:0];
                    end
                    if (rd_en) begin
                        dat_nxt.dout = rd_byte;
                        dat_nxt.doe = (mode == OTPPI_AM_RSVD) ? 8'h00 : 8'hff;
                    end
                end
            end
            OTPPI_ST_LOCKED: begin
                if (mode_pins && sel_fall) begin
                    refused_nxt = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_r <= OTPPI_ST_IDLE;
            ahi_r <= '0;
            lock_r <= '0;
            cnt_r <= '0;
            wr_en_r <= 1'b0;
            vpp_r <= 1'b0;
            dat_r <= '0;
            refused_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            ahi_r <= ahi_nxt;
            lock_r <= lock_nxt;
            cnt_r <= cnt_nxt;
            wr_en_r <= wr_en_nxt;
            vpp_r <= vpp_nxt;
            dat_r <= dat_nxt;
            refused_r <= refused_nxt;
        end
    end

    // array has no reset; content outlives mode changes like real otp
    always_ff @(posedge i_clk) begin
        if (otp_write_pulse_n_mem) begin
            mem[addr] <= i_port0;
        end
    end

    assign o_port0 = dat_r.dout;
    assign o_port0_oe = dat_r.doe;
    assign o_otp_write_pulse_n_mode = (st_r == OTPPI_ST_ACTIVE);
    assign o_otp_write_pulse_n_busy = (cnt_r != '0);
    assign o_entry_refused = refused_r;
endmodule

// ### sim/otppi_chk.sv
// port assertions of the otp programming interface
`timescale 1ns/1ns
`include "otppi_consts.svh"
module otppi_chk #(
    parameter int OTP_WRITE_PULSE_N_CYCLES = `OTPPI_OTP_WRITE_PULSE_N_CYCLES
) (
    // clock, reset and pins
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_basic_mode_sel_n,
    input wire logic i_ext_access_program_supply,
    input wire logic i_access_mode_sel_bit0,
    input wire logic i_access_mode_sel_bit1,
    input wire logic i_otp_read_strobe_n,
    input wire logic i_otp_write_pulse_n,
    input wire logic [7:0] i_port2,
    // outputs
    input wire logic [7:0] o_port0,
    input wire logic [7:0] o_port0_oe,
    input wire logic o_otp_write_pulse_n_mode,
    input wire logic o_otp_write_pulse_n_busy,
    input wire logic o_entry_refused
);
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic [1:0] am;
    logic rd;
    assign am = {i_access_mode_sel_bit1, i_access_mode_sel_bit0};
    assign rd = o_otp_write_pulse_n_mode && !i_otp_read_strobe_n && !o_otp_write_pulse_n_busy;
    always_comb begin
        cnt_nxt = o_otp_write_pulse_n_busy ? cnt_r + 16'h1 : 16'h0;
    end
    always_ff @(posedge i_clk) begin
        cnt_r <= i_rst ? 16'h0 : cnt_nxt;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    AST_BUSY_LEN: assert property ($fell(o_otp_write_pulse_n_busy) |-> cnt_r == OTP_WRITE_PULSE_N_CYCLES)
        else $error("busy length");
    AST_START: assert property ($fell(i_otp_write_pulse_n) && o_otp_write_pulse_n_mode && am[1]
        && i_ext_access_program_supply && !o_otp_write_pulse_n_busy |=> o_otp_write_pulse_n_busy) else $error("no otp_write_pulse_n");
    AST_RD_OE: assert property (rd && am != 2'h0 |=> o_port0_oe == 8'hff)
        else $error("no drive");
    AST_OE_OFF: assert property (i_otp_read_strobe_n |=> o_port0_oe == 8'h00)
        else $error("drive idle");
    AST_RSVD: assert property (am == 2'h0 |=> o_port0_oe == 8'h00)
        else $error("reserved drive");
    AST_VER: assert property (rd && am == 2'h1 |=> o_port0 ==
        ($past(i_port2[0]) ? `OTPPI_VERSION1 : `OTPPI_VERSION0)) else $error("version");
    AST_ENTRY: assert property ($rose(o_otp_write_pulse_n_mode) |-> !i_basic_mode_sel_n
        && $past(i_otp_write_pulse_n)) else $error("entry");
    AST_REFUSED: assert property (o_entry_refused |-> !o_otp_write_pulse_n_mode)
        else $error("refused entry");
    cover property (rd && am == 2'h3);
    cover property ($fell(o_otp_write_pulse_n_busy));
    cover property ($rose(o_entry_refused));
endmodule

// ### sim/otppi_otp_write_pulse_n.sv
// programmer model driving the otp interface pins
`timescale 1ns/1ns
module otppi_otp_write_pulse_n (
    // clock and data bus
    input wire logic i_clk,
    input wire logic [7:0] i_data,
    // rst_n store_n sel_n supply latch am1 am0 rd_n wr_n, port 2, port 0
    output logic [8:0] o_ctl,
    output logic [7:0] o_p2,
    output logic [7:0] o_p0
);
    initial begin
        o_ctl = 9'h1ff;
        o_p2 = 8'h00;
        o_p0 = 8'h00;
    end
    task automatic step(input logic [8:0] c);
        @(posedge i_clk);
        o_ctl <= c;
    endtask
    task automatic enter();
        step(9'h046);
        step(9'h006);
        step(9'h007);
        step(9'h027);
    endtask
    task automatic access(input logic [1:0] am, input logic [15:0] a,
            input logic [7:0] d, input logic wr, output logic [7:0] q);
        step({4'h1, 1'b0, am, 2'b11});
        o_p2 <= a[15:8];
        step({4'h1, 1'b1, am, 2'b11});
        step({4'h1, 1'b0, am, 2'b11});
        step({4'h1, 1'b0, am, wr, !wr});
        o_p2 <= a[7:0];
        o_p0 <= wr ? d : ~d;
        repeat (2) @(posedge i_clk);
        q = i_data;
        step({4'h1, 1'b0, am, 2'b11});
        o_p0 <= ~d;
        repeat (10) @(posedge i_clk);
    endtask
endmodule

// ### sim/otppi_tb_top.sv
// self-checking bench of the otp programming interface
`timescale 1ns/1ns
`include "otppi_consts.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
    $display("unexpected at %0t: %h %h", $time, a, e); end end
module otppi_tb_top;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [8:0] ctl;
    logic [7:0] p2;
    logic [7:0] p0;
    logic [7:0] dout;
    logic [7:0] oe;
    logic [7:0] bus;
    logic mode;
    logic busy;
    logic refused;
    logic [7:0] q;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    assign bus = (dout & oe) | (p0 & ~oe);
    otppi_otp_write_pulse_n otppi_otp_write_pulse_n_i (.i_clk(i_clk), .i_data(bus), .o_ctl(ctl), .o_p2(p2), .o_p0(p0));
    otppi_top #(.OTP_WRITE_PULSE_N_CYCLES(8)) otppi_top_i (
        .i_clk(i_clk), .i_rst(i_rst), .i_reset_pin_n(ctl[8]),
        .i_program_store_enable_n(ctl[7]), .i_basic_mode_sel_n(ctl[6]),
        .i_ext_access_program_supply(ctl[5]), .i_upper_addr_latch_strobe(ctl[4]),
        .i_access_mode_sel_bit1(ctl[3]), .i_access_mode_sel_bit0(ctl[2]),
        .i_otp_read_strobe_n(ctl[1]), .i_otp_write_pulse_n(ctl[0]), .i_port2(p2),
        .i_port0(bus), .o_port0(dout), .o_port0_oe(oe), .o_otp_write_pulse_n_mode(mode),
        .o_otp_write_pulse_n_busy(busy), .o_entry_refused(refused)
    );
    task automatic stop_test();
        if (mismatches == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic t_entry();
        otppi_otp_write_pulse_n_i.enter();
        repeat (3) @(posedge i_clk);
        `CHK(mode, 1'b1)
    endtask
    task automatic t_version();
        for (int i = 0; i < 2; i++) begin
            otppi_otp_write_pulse_n_i.access(2'h1, 16'(i), 8'h00, 1'b0, q);
            `CHK(q, (i == 1) ? `OTPPI_VERSION1 : `OTPPI_VERSION0)
        end
    endtask
    task automatic t_mem();
        otppi_otp_write_pulse_n_i.access(2'h3, 16'h1234, 8'h3c, 1'b1, q);
        otppi_otp_write_pulse_n_i.access(2'h3, 16'h5634, 8'hc3, 1'b1, q);
        otppi_otp_write_pulse_n_i.access(2'h3, 16'h1234, 8'h00, 1'b0, q);
        `CHK(q, 8'h3c)
        otppi_otp_write_pulse_n_i.access(2'h3, 16'h5634, 8'h00, 1'b0, q);
        `CHK(q, 8'hc3)
    endtask
    task automatic t_rsvd();
        otppi_otp_write_pulse_n_i.access(2'h0, 16'h0001, 8'h96, 1'b0, q);
        `CHK(q, 8'h69)
    endtask
    task automatic t_lock();
        otppi_otp_write_pulse_n_i.access(2'h2, 16'h0000, 8'h01, 1'b1, q);
        otppi_otp_write_pulse_n_i.access(2'h2, 16'h0000, 8'h00, 1'b0, q);
        `CHK(q[1:0], 2'h1)
        otppi_otp_write_pulse_n_i.step(9'h1ff);
        repeat (2) @(posedge i_clk);
        otppi_otp_write_pulse_n_i.enter();
        repeat (3) @(posedge i_clk);
        `CHK(refused, 1'b1)
        `CHK(mode, 1'b0)
    endtask
    initial begin
        forever #10 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            mismatches++;
            stop_test();
        end
    end
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        t_entry();
        t_version();
        t_mem();
        t_rsvd();
        t_lock();
        stop_test();
    end
endmodule
bind otppi_top otppi_chk #(.OTP_WRITE_PULSE_N_CYCLES(OTP_WRITE_PULSE_N_CYCLES)) otppi_chk_i (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_basic_mode_sel_n(i_basic_mode_sel_n),
    .i_ext_access_program_supply(i_ext_access_program_supply),
    .i_access_mode_sel_bit0(i_access_mode_sel_bit0),
    .i_access_mode_sel_bit1(i_access_mode_sel_bit1),
    .i_otp_read_strobe_n(i_otp_read_strobe_n),
    .i_otp_write_pulse_n(i_otp_write_pulse_n),
    .i_port2(i_port2),
    .o_port0(o_port0),
    .o_port0_oe(o_port0_oe),
    .o_otp_write_pulse_n_mode(o_otp_write_pulse_n_mode),
    .o_otp_write_pulse_n_busy(o_otp_write_pulse_n_busy),
    .o_entry_refused(o_entry_refused)
);
